/* inc/cssw_pkg.sv */
// Constants, field layout and types of the clock source switch
package cssw_pkg;

    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          NUM_EV          = 4;

    // Register byte addresses
    localparam logic [7:0]  ADDR_PWR_CTRL   = 8'hC4;
    localparam logic [7:0]  ADDR_STATUS     = 8'hC8;
    localparam logic [7:0]  ADDR_IRQ_STAT   = 8'hCC;
    localparam logic [7:0]  ADDR_IRQ_MASK   = 8'hD0;

    // clock_source_power_control fields
    localparam int          BIT_XSEL        = 7;
    localparam int          BIT_RC_ACTIVE   = 6;
    localparam int          BIT_RESUME_RC   = 5;
    localparam int          BIT_SUB_DIS     = 4;
    localparam int          BIT_MAIN_DIS    = 3;

    // Status register fields
    localparam int          BIT_STABLE      = 4;
    localparam int          BIT_HOLD        = 0;

    // Interrupt event bits
    localparam int          EV_STABLE       = 0;
    localparam int          EV_SWITCH       = 1;
    localparam int          EV_WAKE         = 2;
    localparam int          EV_REJECT       = 3;

    // Reset values
    localparam logic        XSEL_RST        = 1'b0;
    localparam logic        RESUME_RC_RST   = 1'b0;
    localparam logic        SUB_DIS_RST     = 1'b0;
    localparam logic        MAIN_DIS_RST    = 1'b0;
    localparam logic [NUM_EV-1:0] IRQ_MASK_RST = 4'h0;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    localparam int          WARMUP_CYC_DEF  = 2048;
    localparam int          WARMUP_W        = 16;

    typedef enum logic [1:0] {
        CS_RUN,
        CS_PDOWN,
        CS_HOLD
    } cssw_state_e;

endpackage : cssw_pkg

/* inc/cssw_osc_if.sv */
// Signals between the switch controller and the warm-up timer
interface cssw_osc_if;
    logic ce;
    logic enable;
    logic running;
    logic stable;

    modport ctrl (
        output ce,
        output enable,
        output running,
        input  stable
    );

    modport timer (
        input  ce,
        input  enable,
        input  running,
        output stable
    );
endinterface : cssw_osc_if

/* rtl/cssw_warmup.sv */
// Crystal warm-up timer that raises the stable flag
module cssw_warmup
    import cssw_pkg::*;
#(
    parameter int WARMUP_CYCLES = WARMUP_CYC_DEF
) (
    input wire logic  mclk,
    input wire logic  reset_n,
    cssw_osc_if.timer osc
);

    localparam logic [WARMUP_W-1:0] CNT_END = WARMUP_W'(WARMUP_CYCLES - 1);

    logic [WARMUP_W-1:0] cnt_ff;
    logic                stable_ff;

    // Count only while enabled and oscillating; any stop restarts warm-up
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cnt_ff    <= '0;
            stable_ff <= 1'b0;
        end else if (osc.ce) begin
            if (!osc.enable || !osc.running) begin
                cnt_ff    <= '0;
                stable_ff <= 1'b0;
            end else if (cnt_ff == CNT_END) begin
                stable_ff <= 1'b1;
            end else begin
                cnt_ff    <= cnt_ff + WARMUP_W'(1);
            end
        end
    end

    assign osc.stable = stable_ff;

endmodule : cssw_warmup

/* rtl/cssw_top.sv */
// Clock source switch with AXI4-Lite registers and interrupt
// Notes on behaviour
// - Select bit one: run from crystal
// - Select bit zero: run from RC
// - Select set only if stable, main enabled
// - Refused select set leaves bit unchanged
// - RC status reads zero on crystal
// - RC status reads one on RC
// - Resume-on-RC: wake immediately on RC
// - Otherwise hold after wake until warm or main disabled
// - Sub disable bit stops 32 kHz oscillator
// - Main disable bit stops crystal oscillator
// - Main disable settable only on RC
// - Clearing main disable restarts crystal
// - Stable flag set after warm-up completes
//
// Decided for this implementation: the AXI4-Lite slave port.
module cssw_top
    import cssw_pkg::*;
#(
    parameter int WARMUP_CYCLES = WARMUP_CYC_DEF
) (
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              xtal_running,
    input  wire logic              pd_req,
    input  wire logic              wake_req,
    output logic                   clk_sel_xtal,
    output logic                   main_osc_en,
    output logic                   sub_osc_en,
    output logic                   cpu_hold,
    output logic                   irq
);

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = 1'b0;
        if (a == ADDR_PWR_CTRL) begin
            ok = 1'b1;
        end else if (a == ADDR_STATUS) begin
            ok = 1'b1;
        end else if (a == ADDR_IRQ_STAT) begin
            ok = 1'b1;
        end else if (a == ADDR_IRQ_MASK) begin
            ok = 1'b1;
        end
        return ok;
    endfunction : addr_mapped

    cssw_osc_if osc_if ();

    logic              awready_ff;
    logic              wready_ff;
    logic              aw_hold_ff;
    logic              w_hold_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [3:0]        wstrb_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              arready_ff;
    logic              rvalid_ff;
    logic [1:0]        rresp_ff;
    logic [DATA_W-1:0] rdata_ff;

    logic              xtal_meta_ff;
    logic              xtal_sync_ff;

    logic              xsel_ff;
    logic              rc_active_ff;
    logic              resume_rc_ff;
    logic              sub_dis_ff;
    logic              main_dis_ff;
    logic              main_osc_en_ff;
    logic              sub_osc_en_ff;
    logic              cpu_hold_ff;
    cssw_state_e       state_ff;
    cssw_state_e       nxt_state;

    logic [NUM_EV-1:0] ist_ff;
    logic [NUM_EV-1:0] imask_ff;
    logic [NUM_EV-1:0] ev;
    logic              irq_ff;
    logic              stable_d_ff;

    logic              wr_fire;
    logic              wr_lane0;
    logic              wr_ctrl;
    logic              wr_istat;
    logic              wr_imask;
    logic              xsel_ok;
    logic              xsel_set_req;
    logic              xsel_reject;
    logic              mdis_set_req;
    logic              mdis_reject;
    logic              wake_to_rc;
    logic              wake_done;
    logic [7:0]        ctrl_byte;
    logic [7:0]        stat_byte;
    logic              stable;

    function automatic logic s_axi_wdata_bit(input int pos);
        return wdata_ff[pos];
    endfunction : s_axi_wdata_bit

    assign stable = osc_if.stable;

    // Two-stage synchroniser for the oscillator running pin
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            xtal_meta_ff <= 1'b0;
            xtal_sync_ff <= 1'b0;
        end else if (ce) begin
            xtal_meta_ff <= xtal_running;
            xtal_sync_ff <= xtal_meta_ff;
        end
    end

    assign osc_if.ce      = ce;
    assign osc_if.enable  = main_osc_en_ff;
    assign osc_if.running = xtal_sync_ff;

    cssw_warmup #(
        .WARMUP_CYCLES (WARMUP_CYCLES)
    ) u_warmup (
        .mclk    (mclk),
        .reset_n (reset_n),
        .osc     (osc_if.timer)
    );

    // Write address and data channels, taken in either order
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            awready_ff <= 1'b0;
            aw_hold_ff <= 1'b0;
            awaddr_ff  <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && awready_ff) begin
                awready_ff <= 1'b0;
                aw_hold_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold_ff <= 1'b0;
            end else if (!aw_hold_ff && !bvalid_ff) begin
                awready_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wready_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            wdata_ff  <= '0;
            wstrb_ff  <= '0;
        end else if (ce) begin
            if (s_axi_wvalid && wready_ff) begin
                wready_ff <= 1'b0;
                w_hold_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_ff <= 1'b0;
            end else if (!w_hold_ff && !bvalid_ff) begin
                wready_ff <= 1'b1;
            end
        end
    end

    assign wr_fire  = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign wr_lane0 = wr_fire && wstrb_ff[0];
    assign wr_ctrl  = wr_lane0 && (awaddr_ff == ADDR_PWR_CTRL);
    assign wr_istat = wr_lane0 && (awaddr_ff == ADDR_IRQ_STAT);
    assign wr_imask = wr_lane0 && (awaddr_ff == ADDR_IRQ_MASK);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= addr_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Write-side interlocks on the control bits
    assign xsel_ok      = stable && !main_dis_ff;
    assign xsel_set_req = wr_ctrl && s_axi_wdata_bit(BIT_XSEL) && !xsel_ff;
    assign xsel_reject  = xsel_set_req && !xsel_ok;
    assign mdis_set_req = wr_ctrl && s_axi_wdata_bit(BIT_MAIN_DIS)
                          && !main_dis_ff;
    assign mdis_reject  = mdis_set_req && xsel_ff;

    // Power-down and wake sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CS_RUN: begin
                if (pd_req) begin
                    nxt_state = CS_PDOWN;
                end
            end
            CS_PDOWN: begin
                if (wake_req) begin
                    nxt_state = resume_rc_ff ? CS_RUN : CS_HOLD;
                end
            end
            CS_HOLD: begin
                if (stable || main_dis_ff) begin
                    nxt_state = CS_RUN;
                end
            end
            default: begin
                nxt_state = CS_RUN;
            end
        endcase
    end

    assign wake_to_rc = (state_ff == CS_PDOWN) && wake_req && resume_rc_ff;
    assign wake_done  = (state_ff != CS_RUN) && (nxt_state == CS_RUN);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_ff <= CS_RUN;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // Clock source select and oscillator disables
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            xsel_ff      <= XSEL_RST;
            resume_rc_ff <= RESUME_RC_RST;
            sub_dis_ff   <= SUB_DIS_RST;
            main_dis_ff  <= MAIN_DIS_RST;
        end else if (ce) begin
            if (wake_to_rc) begin
                xsel_ff <= 1'b0;
            end else if (wr_ctrl) begin
                if (!s_axi_wdata_bit(BIT_XSEL)) begin
                    xsel_ff <= 1'b0;
                end else if (xsel_ok) begin
                    xsel_ff <= 1'b1;
                end
            end
            if (wr_ctrl) begin
                resume_rc_ff <= s_axi_wdata_bit(BIT_RESUME_RC);
                sub_dis_ff   <= s_axi_wdata_bit(BIT_SUB_DIS);
                if (!s_axi_wdata_bit(BIT_MAIN_DIS)) begin
                    main_dis_ff <= 1'b0;
                end else if (!xsel_ff) begin
                    main_dis_ff <= 1'b1;
                end
            end
        end
    end

    // Registered outputs toward the clock tree and oscillators
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rc_active_ff   <= !XSEL_RST;
            main_osc_en_ff <= 1'b0;
            sub_osc_en_ff  <= 1'b0;
            cpu_hold_ff    <= 1'b0;
        end else if (ce) begin
            rc_active_ff   <= !xsel_ff;
            main_osc_en_ff <= !main_dis_ff && (state_ff != CS_PDOWN);
            sub_osc_en_ff  <= !sub_dis_ff;
            cpu_hold_ff    <= (nxt_state != CS_RUN);
        end
    end

    // Interrupt status: hardware set wins over write-one-to-clear
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            stable_d_ff <= 1'b0;
        end else if (ce) begin
            stable_d_ff <= stable;
        end
    end

    always_comb begin
        ev            = '0;
        ev[EV_STABLE] = stable && !stable_d_ff;
        ev[EV_SWITCH] = rc_active_ff == xsel_ff;
        ev[EV_WAKE]   = wake_done;
        ev[EV_REJECT] = xsel_reject || mdis_reject;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ist_ff   <= '0;
            imask_ff <= IRQ_MASK_RST;
            irq_ff   <= 1'b0;
        end else if (ce) begin
            if (wr_istat) begin
                ist_ff <= (ist_ff & ~wdata_ff[NUM_EV-1:0]) | ev;
            end else begin
                ist_ff <= ist_ff | ev;
            end
            if (wr_imask) begin
                imask_ff <= wdata_ff[NUM_EV-1:0];
            end
            irq_ff <= |(ist_ff & imask_ff);
        end
    end

    // Read channel
    always_comb begin
        ctrl_byte                = '0;
        ctrl_byte[BIT_XSEL]      = xsel_ff;
        ctrl_byte[BIT_RC_ACTIVE] = rc_active_ff;
        ctrl_byte[BIT_RESUME_RC] = resume_rc_ff;
        ctrl_byte[BIT_SUB_DIS]   = sub_dis_ff;
        ctrl_byte[BIT_MAIN_DIS]  = main_dis_ff;
        stat_byte                = '0;
        stat_byte[BIT_STABLE]    = stable;
        stat_byte[BIT_HOLD]      = cpu_hold_ff;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= RESP_OKAY;
            rdata_ff   <= '0;
        end else if (ce) begin
            if (s_axi_arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff  <= 1'b1;
                rdata_ff   <= '0;
                rresp_ff   <= RESP_OKAY;
                if (s_axi_araddr == ADDR_PWR_CTRL) begin
                    rdata_ff[7:0] <= ctrl_byte;
                end else if (s_axi_araddr == ADDR_STATUS) begin
                    rdata_ff[7:0] <= stat_byte;
                end else if (s_axi_araddr == ADDR_IRQ_STAT) begin
                    rdata_ff[NUM_EV-1:0] <= ist_ff;
                end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
                    rdata_ff[NUM_EV-1:0] <= imask_ff;
                end else begin
                    rresp_ff <= RESP_SLVERR;
                end
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff  <= 1'b0;
                arready_ff <= 1'b1;
            end else if (!rvalid_ff && !arready_ff) begin
                arready_ff <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;
    assign clk_sel_xtal  = xsel_ff;
    assign main_osc_en   = main_osc_en_ff;
    assign sub_osc_en    = sub_osc_en_ff;
    assign cpu_hold      = cpu_hold_ff;
    assign irq           = irq_ff;

endmodule : cssw_top

/* verification/cssw_xtal_model.sv */
// Behavioural crystal oscillator that starts a while after enable
module cssw_xtal_model #(
    parameter int START_CYC = 40
) (
    input  wire logic mclk,
    input  wire logic enable,
    output logic      running
);
    timeunit 1ns;
    timeprecision 1ps;

    int count = 0;

    // Oscillation stops at once when disabled, restarts after start-up
    always @(posedge mclk) begin
        if (!enable) begin
            count <= 0;
        end else if (count < START_CYC) begin
            count <= count + 1;
        end
    end

    assign running = enable && (count == START_CYC);
endmodule : cssw_xtal_model

/* verification/cssw_top_props.sv */
// Concurrent checks on the ports of the clock source switch
module cssw_top_props
    import cssw_pkg::*;
#(
    parameter int WARMUP_CYCLES = WARMUP_CYC_DEF
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic xtal_running,
    input wire logic pd_req,
    input wire logic wake_req,
    input wire logic clk_sel_xtal,
    input wire logic main_osc_en,
    input wire logic cpu_hold,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence s_pd_taken;
        ce && pd_req && !cpu_hold ##1 cpu_hold;
    endsequence

    sequence s_quick_wake;
        cpu_hold && wake_req ##1 !cpu_hold;
    endsequence

    a_pd_raises_hold: assert property (
        ce && pd_req && !cpu_hold |=> cpu_hold)
        else $error("power-down request did not raise hold");
    a_pd_stops_main: assert property (
        s_pd_taken |=> !main_osc_en)
        else $error("crystal kept running in power-down");
    a_wake_on_rc: assert property (
        s_quick_wake |-> !clk_sel_xtal)
        else $error("immediate wake not on RC clock");
    a_hold_until_warm: assert property (
        $fell(cpu_hold) && clk_sel_xtal |-> $past(xtal_running, 3))
        else $error("hold released before crystal ran");
    a_sel_needs_xtal: assert property (
        $rose(clk_sel_xtal) |-> main_osc_en && $past(xtal_running, 3))
        else $error("crystal selected while not running");
    a_main_off_rc: assert property (
        !main_osc_en && !cpu_hold |-> !clk_sel_xtal)
        else $error("crystal stopped while it clocks the core");
    a_read_answer: assert property (
        ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_single: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_irq_clear_write: assert property (
        $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid)
            || $past(s_axi_bvalid, 2))
        else $error("interrupt fell without a write");
endmodule : cssw_top_props

bind cssw_top cssw_top_props #(
    .WARMUP_CYCLES(WARMUP_CYCLES)
) u_props (
    .mclk(mclk), .reset_n(reset_n), .ce(ce), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .xtal_running(xtal_running), .pd_req(pd_req), .wake_req(wake_req),
    .clk_sel_xtal(clk_sel_xtal), .main_osc_en(main_osc_en),
    .cpu_hold(cpu_hold), .irq(irq)
);

/* verification/cssw_top_tb.sv */
// Self-checking bench of the clock source switch
`define chk(got, exp) begin compares++; if ((got) !== (exp)) begin \
    bad_count++; $display("wrong value at %0t: got %0h expected %0h", \
    $time, got, exp); end end

module cssw_top_tb
    import cssw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0, reset_n = 1'b0, ce = 1'b1;
    logic pd_req = 1'b0, wake_req = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, xtal_running;
    logic clk_sel_xtal, main_osc_en, sub_osc_en, cpu_hold, irq;
    int bad_count = 0, compares = 0, cycles = 0;

    always #10 mclk = ~mclk;

    cssw_top #(.WARMUP_CYCLES(4)) dut (
        .mclk, .reset_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .xtal_running, .pd_req, .wake_req,
        .clk_sel_xtal, .main_osc_en, .sub_osc_en, .cpu_hold, .irq
    );

    cssw_xtal_model #(.START_CYC(40)) xtal (
        .mclk(mclk), .enable(main_osc_en), .running(xtal_running)
    );

    task automatic close_out();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        bit aw_ok = 0;
        bit w_ok = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axr

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        axr(a);
        `chk(rsp, RESP_OKAY)
        `chk(rd[7:0], e)
    endtask : rchk

    task automatic wait_stable();
        int n = 0;
        do begin
            axr(ADDR_STATUS);
            n++;
        end while (rd[BIT_STABLE] !== 1'b1 && n < 100);
    endtask : wait_stable

    // Sleep, then wake; the caller judges how the wake ends
    task automatic power_cycle();
        pd_req <= 1'b1;
        @(posedge mclk);
        pd_req <= 1'b0;
        @(posedge mclk);
        `chk(cpu_hold, 1'b1)
        @(posedge mclk);
        `chk(main_osc_en, 1'b0)
        wake_req <= 1'b1;
        @(posedge mclk);
        wake_req <= 1'b0;
        @(posedge mclk);
    endtask : power_cycle

    task automatic t_reset_vals();
        rchk(ADDR_PWR_CTRL, 8'h40);
        `chk(clk_sel_xtal, 1'b0)
        `chk(sub_osc_en, 1'b1)
        rchk(ADDR_IRQ_MASK, 8'h00);
        axr(8'hF0);
        `chk(rsp, RESP_SLVERR)
        `chk(rd, 32'h0)
    endtask : t_reset_vals

    task automatic t_select_refused();
        axw(ADDR_PWR_CTRL, 32'h80);
        rchk(ADDR_PWR_CTRL, 8'h40);
        `chk(clk_sel_xtal, 1'b0)
        axr(ADDR_IRQ_STAT);
        `chk(rd[EV_REJECT], 1'b1)
    endtask : t_select_refused

    task automatic t_select_xtal();
        axr(ADDR_STATUS);
        `chk(rd[BIT_STABLE], 1'b0)
        wait_stable();
        `chk(rd[BIT_STABLE], 1'b1)
        axw(ADDR_PWR_CTRL, 32'h80);
        rchk(ADDR_PWR_CTRL, 8'h80);
        `chk(clk_sel_xtal, 1'b1)
        axw(ADDR_PWR_CTRL, 32'h88);
        rchk(ADDR_PWR_CTRL, 8'h80);
        `chk(main_osc_en, 1'b1)
    endtask : t_select_xtal

    task automatic t_main_disable();
        axw(ADDR_PWR_CTRL, 32'h00);
        rchk(ADDR_PWR_CTRL, 8'h40);
        `chk(clk_sel_xtal, 1'b0)
        axw(ADDR_PWR_CTRL, 32'h08);
        rchk(ADDR_PWR_CTRL, 8'h48);
        `chk(main_osc_en, 1'b0)
        axw(ADDR_PWR_CTRL, 32'h88);
        rchk(ADDR_PWR_CTRL, 8'h48);
        axw(ADDR_PWR_CTRL, 32'h00);
        rchk(ADDR_PWR_CTRL, 8'h40);
        `chk(main_osc_en, 1'b1)
        axr(ADDR_STATUS);
        `chk(rd[BIT_STABLE], 1'b0)
        wait_stable();
        `chk(rd[BIT_STABLE], 1'b1)
    endtask : t_main_disable

    task automatic t_sub_osc();
        axw(ADDR_PWR_CTRL, 32'h10);
        rchk(ADDR_PWR_CTRL, 8'h50);
        `chk(sub_osc_en, 1'b0)
        axw(ADDR_PWR_CTRL, 32'h00);
        @(posedge mclk);
        `chk(sub_osc_en, 1'b1)
    endtask : t_sub_osc

    // Clock enable low must freeze the power-down sequencer
    task automatic t_ce_freeze();
        ce <= 1'b0;
        pd_req <= 1'b1;
        repeat (3) @(posedge mclk);
        `chk(cpu_hold, 1'b0)
        pd_req <= 1'b0;
        ce <= 1'b1;
        @(posedge mclk);
        `chk(cpu_hold, 1'b0)
    endtask : t_ce_freeze

    task automatic t_resume_rc();
        axw(ADDR_PWR_CTRL, 32'hA0);
        rchk(ADDR_PWR_CTRL, 8'hA0);
        power_cycle();
        `chk(cpu_hold, 1'b0)
        `chk(clk_sel_xtal, 1'b0)
        rchk(ADDR_PWR_CTRL, 8'h60);
    endtask : t_resume_rc

    task automatic t_resume_xtal();
        int n = 0;
        axw(ADDR_PWR_CTRL, 32'h00);
        wait_stable();
        axw(ADDR_PWR_CTRL, 32'h80);
        power_cycle();
        `chk(cpu_hold, 1'b1)
        while (cpu_hold !== 1'b0 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        `chk(cpu_hold, 1'b0)
        `chk(clk_sel_xtal, 1'b1)
        axr(ADDR_STATUS);
        `chk(rd[BIT_STABLE], 1'b1)
    endtask : t_resume_xtal

    task automatic t_irq();
        axr(ADDR_IRQ_STAT);
        `chk(rd[3:0], 4'hF)
        `chk(irq, 1'b0)
        axw(ADDR_IRQ_MASK, 32'h08);
        repeat (3) @(posedge mclk);
        `chk(irq, 1'b1)
        axw(ADDR_IRQ_STAT, 32'h08);
        repeat (3) @(posedge mclk);
        `chk(irq, 1'b0)
        rchk(ADDR_IRQ_STAT, 8'h07);
        axw(ADDR_IRQ_MASK, 32'h0F);
        repeat (3) @(posedge mclk);
        `chk(irq, 1'b1)
        axw(ADDR_IRQ_STAT, 32'h0F);
        repeat (3) @(posedge mclk);
        `chk(irq, 1'b0)
        rchk(ADDR_IRQ_STAT, 8'h00);
        axw(8'hF0, 32'hFF);
        `chk(rsp, RESP_SLVERR)
    endtask : t_irq

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset_vals();
        t_select_refused();
        t_select_xtal();
        t_main_disable();
        t_sub_osc();
        t_resume_rc();
        t_resume_xtal();
        t_irq();
        t_ce_freeze();
        close_out();
    end
endmodule : cssw_top_tb
